// File: hw/cmsd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module cmsd_decoder
  import cmsd_pkg::*;
#(
  parameter int REC_BITS = CMSD_REC_BITS
) (
  input wire logic core_clk_in,                     // System clock, 25 MHz.
  input wire logic sys_rst_in,                      // Synchronous reset, active high.
  input wire logic req_valid_in,                    // Data space request offered.
  output logic req_ready_out,                       // Request taken this cycle when valid.
  input wire cmsd_req_e req_kind_in,                // Operand or stack request kind.
  input wire logic req_write_in,                    // Write request when high, read when low.
  input wire logic [7:0] req_field_in,              // Register index, direct address or bit address.
  input wire logic [15:0] req_wdata_in,             // Write byte in low half; call return address in full.
  input wire logic req_bit_in,                      // Bit value for a bit write.
  output logic done_out,                            // Request complete, one-cycle pulse.
  output logic [15:0] rdata_out,                    // Read result, held until the next completion.
  input wire logic [7:0] program_status_word_in,    // Status word holding the bank select bits.
  output logic [7:0] stack_pointer_out,             // Current stack pointer.
  output logic sfr_rd_out,                          // External SFR read strobe.
  output logic sfr_wr_out,                          // External SFR write strobe.
  output logic [7:0] sfr_addr_out,                  // External SFR address.
  output logic [7:0] sfr_wdata_out,                 // External SFR write data.
  input wire logic [7:0] sfr_rdata_in,              // External SFR read data, the cycle after the strobe.
  output logic stack_overflow_out,                  // Stack record overflow pulse to debug.
  output logic stack_underflow_out,                 // Stack record underflow pulse to debug.
  output logic [$clog2(REC_BITS+1)-1:0] stack_depth_out, // Record bits held.
  output logic [REC_BITS-1:0] stack_record_out,     // Record contents, newest bit at bit 0.
  input wire logic br_valid_in,                     // Branch target request.
  input wire cmsd_br_e br_kind_in,                  // Branch target kind.
  input wire logic [15:0] br_next_pc_in,            // Address of first byte of the next instruction.
  input wire logic [15:0] br_field_in,              // Offset, 11-bit page address or 16-bit address.
  output logic br_valid_out,                        // Target ready, one-cycle pulse.
  output logic [15:0] br_target_out,                // Computed target.
  output logic br_in_flash_out,                     // Target lies inside implemented flash.
  input wire logic [7:0] opcode_in,                 // Opcode under decode.
  output logic opcode_nop_out,                      // Registered: opcode acts as no_operation.
  input wire logic [7:0] program_store_control_in,  // Program store control register value.
  input wire logic xmove_wr_in,                     // External_move_instruction write strobe.
  input wire logic [15:0] xmove_addr_in,            // External_move_instruction address.
  input wire logic [7:0] xmove_wdata_in,            // External_move_instruction data.
  output logic flash_wr_out,                        // Program memory write pulse.
  output logic xram_wr_out,                         // External data memory write pulse.
  output logic flash_range_err_out,                 // Redirected write beyond flash, dropped.
  output logic [15:0] xdest_addr_out,               // Address of the redirected or passed write.
  output logic [7:0] xdest_wdata_out                // Data of that write.
);

  localparam int CW = $clog2(REC_BITS+1);
  localparam logic [CW:0] REC_FULL = (CW+1)'(REC_BITS);

  // Three bits keep the two-bit shift selects legal; beyond 63 the counter sizing stops being checked.
  if (REC_BITS < 3 || REC_BITS > 63)
  begin : g_bad_rec
    $error("cmsd_decoder: REC_BITS must lie in 3..63");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PTR,
    ST_ISSUE,
    ST_READ,
    ST_CALL_HI,
    ST_RET_LO
  } cmsd_state_e;

  // Register number plus bank times eight, shared by direct and indirect bank access.
  function automatic logic [7:0] cmsd_bank_addr(input logic [1:0] bank, input logic [2:0] idx);
    return {3'h0, bank, idx};
  endfunction : cmsd_bank_addr

  cmsd_state_e state_q, state_d;
  cmsd_req_e kind_q, kind_d;
  logic [7:0] addr_q, addr_d;
  logic sfr_q, sfr_d;
  logic write_q, write_d;
  logic bitop_q, bitop_d;
  logic [2:0] bitpos_q, bitpos_d;
  logic bitval_q, bitval_d;
  logic [15:0] wdata_q, wdata_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] sp_q, sp_d;
  logic done_q, done_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0] ram_addr;
  logic ram_wr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;

  // Operand decoding for the request in hand.
  wire [1:0] bank = {program_status_word_in[CMSD_PSW_BANK_HIGH_BIT],
                     program_status_word_in[CMSD_PSW_BANK_LOW_BIT]};
  wire [7:0] reg_addr = cmsd_bank_addr(bank, req_field_in[2:0]);
  wire [7:0] ptr_addr = cmsd_bank_addr(bank, {2'h0, req_field_in[0]});
  wire direct_sfr = req_field_in[CMSD_UPPER_SEL_BIT];
  wire [7:0] bit_ram_addr = CMSD_BIT_RAM_BASE | {4'h0, req_field_in[6:3]};
  wire [7:0] bit_sfr_addr = {req_field_in[7:3], 3'h0};
  wire [7:0] sp_inc = sp_q + 8'h01;
  wire [7:0] sp_dec = sp_q - 8'h01;
  wire accept = (state_q == ST_IDLE) && req_valid_in;
  wire hit_sp = sfr_q && (addr_q == CMSD_SP_SFR_ADDR);

  // Byte returned by the access issued last cycle, and the same byte with one bit replaced.
  wire [7:0] rd_byte = sfr_q ? (hit_sp ? sp_q : sfr_rdata_in) : ram_rdata;
  wire [7:0] bit_mask = 8'h01 << bitpos_q;
  wire [7:0] merged = bitval_q ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);

  assign req_ready_out = (state_q == ST_IDLE);
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign stack_pointer_out = sp_q;

  // Request sequencer: one request in flight; memory and SFR accesses have one cycle of read latency.
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    addr_d = addr_q;
    sfr_d = sfr_q;
    write_d = write_q;
    bitop_d = bitop_q;
    bitpos_d = bitpos_q;
    bitval_d = bitval_q;
    wdata_d = wdata_q;
    hi_d = hi_q;
    sp_d = sp_q;
    done_d = 1'h0;
    rdata_d = rdata_q;
    ram_addr = addr_q;
    ram_wr = 1'h0;
    ram_wdata = wdata_q[7:0];
    sfr_rd_out = 1'h0;
    sfr_wr_out = 1'h0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (req_valid_in)
        begin
          kind_d = req_kind_in;
          write_d = req_write_in;
          wdata_d = req_wdata_in;
          bitval_d = req_bit_in;
          bitpos_d = req_field_in[2:0];
          bitop_d = (req_kind_in == CMSD_REQ_BIT);
          sfr_d = 1'h0;
          state_d = ST_ISSUE;
          unique case (req_kind_in)
            CMSD_REQ_BANK_REG: addr_d = reg_addr;
            CMSD_REQ_INDIRECT:
            begin
              // Pointer byte is fetched first; the access never reaches the SFRs.
              ram_addr = ptr_addr;
              state_d = ST_PTR;
            end
            CMSD_REQ_DIRECT:
            begin
              addr_d = req_field_in;
              sfr_d = direct_sfr;
            end
            CMSD_REQ_BIT:
            begin
              // Bit addresses 80-FF only ever land on SFRs ending 0 or 8.
              addr_d = direct_sfr ? bit_sfr_addr : bit_ram_addr;
              sfr_d = direct_sfr;
            end
            CMSD_REQ_PUSH, CMSD_REQ_CALL: addr_d = sp_inc;
            CMSD_REQ_POP, CMSD_REQ_RET: addr_d = sp_q;
            CMSD_REQ_SP_INC, CMSD_REQ_SP_DEC: addr_d = sp_q;
          endcase
        end
      end
      ST_PTR:
      begin
        // Full 8-bit pointer reaches all 256 RAM bytes, upper half included.
        addr_d = ram_rdata;
        state_d = ST_ISSUE;
      end
      ST_ISSUE:
      begin
        state_d = ST_READ;
        unique case (kind_q)
          CMSD_REQ_PUSH, CMSD_REQ_CALL:
          begin
            // Store at pointer plus one, then advance; the stack wraps over the whole RAM.
            ram_addr = sp_inc;
            ram_wr = 1'h1;
            sp_d = sp_inc;
            state_d = (kind_q == CMSD_REQ_CALL) ? ST_CALL_HI : ST_IDLE;
            done_d = (kind_q == CMSD_REQ_PUSH);
          end
          CMSD_REQ_POP, CMSD_REQ_RET:
          begin
            ram_addr = sp_q;
            sp_d = sp_dec;
            state_d = (kind_q == CMSD_REQ_RET) ? ST_RET_LO : ST_READ;
          end
          CMSD_REQ_SP_INC, CMSD_REQ_SP_DEC:
          begin
            sp_d = (kind_q == CMSD_REQ_SP_INC) ? sp_inc : sp_dec;
            rdata_d = {8'h00, sp_d};
            done_d = 1'h1;
            state_d = ST_IDLE;
          end
          default:
          begin
            // Plain writes finish here; reads and bit writes need the old byte first.
            if (write_q && !bitop_q)
            begin
              ram_wr = !sfr_q;
              sfr_wr_out = sfr_q && !hit_sp;
              if (hit_sp)
              begin
                sp_d = wdata_q[7:0];
              end
              done_d = 1'h1;
              state_d = ST_IDLE;
            end
            else
            begin
              sfr_rd_out = sfr_q && !hit_sp;
            end
          end
        endcase
      end
      ST_CALL_HI:
      begin
        // Return address goes low byte first, high byte on top.
        ram_addr = sp_inc;
        ram_wr = 1'h1;
        ram_wdata = wdata_q[15:8];
        sp_d = sp_inc;
        done_d = 1'h1;
        state_d = ST_IDLE;
      end
      ST_RET_LO:
      begin
        hi_d = ram_rdata;
        ram_addr = sp_q;
        sp_d = sp_dec;
        state_d = ST_READ;
      end
      ST_READ:
      begin
        done_d = 1'h1;
        state_d = ST_IDLE;
        if (bitop_q && write_q)
        begin
          // Read-modify-write of the holding byte; the other seven bits are kept.
          ram_wr = !sfr_q;
          ram_wdata = merged;
          sfr_wr_out = sfr_q && !hit_sp;
        end
        else if (bitop_q)
        begin
          rdata_d = {15'h0000, rd_byte[bitpos_q]};
        end
        else if (kind_q == CMSD_REQ_RET)
        begin
          rdata_d = {hi_q, rd_byte};
        end
        else
        begin
          rdata_d = {8'h00, rd_byte};
        end
      end
    endcase
  end

  // External SFR port carries the current address and the byte to write.
  assign sfr_addr_out = addr_q;
  assign sfr_wdata_out = bitop_q ? merged : wdata_q[7:0];

  // Sequencer state; the pointer comes out of reset ready for its first push at 08.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_IDLE;
      sp_q <= CMSD_SP_RESET;
      done_q <= 1'h0;
      rdata_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      sp_q <= sp_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  // Request context needs no reset; it is loaded before any use.
  always_ff @(posedge core_clk_in)
  begin
    kind_q <= kind_d;
    addr_q <= addr_d;
    sfr_q <= sfr_d;
    write_q <= write_d;
    bitop_q <= bitop_d;
    bitpos_q <= bitpos_d;
    bitval_q <= bitval_d;
    wdata_q <= wdata_d;
    hi_q <= hi_d;
  end

  cmsd_ram #(
    .WIDTH(CMSD_DATA_BITS),
    .DEPTH(CMSD_RAM_BYTES)
  ) u_ram (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .addr_in(ram_addr),
    .wr_in(ram_wr),
    .wdata_in(ram_wdata),
    .rdata_out(ram_rdata)
  );

  // Stack record bookkeeping, counted when a stack request is accepted.
  wire rec_push = accept && (req_kind_in == CMSD_REQ_PUSH || req_kind_in == CMSD_REQ_SP_INC
                             || req_kind_in == CMSD_REQ_CALL);
  wire rec_pop = accept && (req_kind_in == CMSD_REQ_POP || req_kind_in == CMSD_REQ_SP_DEC
                            || req_kind_in == CMSD_REQ_RET);
  wire rec_two = (req_kind_in == CMSD_REQ_CALL) || (req_kind_in == CMSD_REQ_RET);
  wire [CW:0] rec_n = rec_two ? (CW+1)'(2) : (CW+1)'(1);
  logic [REC_BITS-1:0] rec_q;
  logic [CW-1:0] cnt_q;
  logic ovf_q, unf_q;
  wire [CW:0] cnt_wide = {1'h0, cnt_q};
  wire [CW:0] cnt_sum = cnt_wide + rec_n;
  wire rec_over = cnt_sum > REC_FULL;
  wire rec_under = cnt_wide < rec_n;
  wire [REC_BITS-1:0] rec_shl = rec_two ? {rec_q[REC_BITS-3:0], 2'h3} : {rec_q[REC_BITS-2:0], 1'h0};
  wire [REC_BITS-1:0] rec_shr = rec_two ? {2'h0, rec_q[REC_BITS-1:2]} : {1'h0, rec_q[REC_BITS-1:1]};
  wire [CW:0] cnt_push = rec_over ? REC_FULL : cnt_sum;
  wire [CW:0] cnt_pop = rec_under ? '0 : (cnt_wide - rec_n);

  // Calls mark two set bits, pushes one clear bit; the oldest bits fall off on overflow.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      rec_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'h0;
      unf_q <= 1'h0;
    end
    else
    begin
      rec_q <= rec_push ? rec_shl : (rec_pop ? rec_shr : rec_q);
      cnt_q <= rec_push ? cnt_push[CW-1:0] : (rec_pop ? cnt_pop[CW-1:0] : cnt_q);
      ovf_q <= rec_push && rec_over;
      unf_q <= rec_pop && rec_under;
    end
  end

  assign stack_record_out = rec_q;
  assign stack_depth_out = cnt_q;
  assign stack_overflow_out = ovf_q;
  assign stack_underflow_out = unf_q;

  // Branch targets: the offset is sign extended, the page comes from the next instruction.
  wire [15:0] rel_target = br_next_pc_in + {{8{br_field_in[7]}}, br_field_in[7:0]};
  wire [15:0] abs_target = {br_next_pc_in[15:CMSD_ABS_BITS], br_field_in[CMSD_ABS_BITS-1:0]};
  wire [15:0] br_target = (br_kind_in == CMSD_BR_REL) ? rel_target :
                          (br_kind_in == CMSD_BR_ABS) ? abs_target : br_field_in;

  // Opcode A5 is folded onto no_operation so no separate execution path exists.
  wire is_nop = (opcode_in == CMSD_OP_NOP) || (opcode_in == CMSD_OP_ALT_NOP);

  // External writes up to 207F turn into flash writes while store enable is set; the factory area is not guarded.
  wire to_flash = program_store_control_in[CMSD_PROGRAM_STORE_CONTROL_WE_BIT];
  wire flash_ok = xmove_addr_in <= CMSD_FLASH_LAST;

  // Side decoders are registered so every one of their outputs comes from a flip-flop.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      br_valid_out <= 1'h0;
      br_target_out <= '0;
      br_in_flash_out <= 1'h0;
      opcode_nop_out <= 1'h0;
      flash_wr_out <= 1'h0;
      xram_wr_out <= 1'h0;
      flash_range_err_out <= 1'h0;
      xdest_addr_out <= '0;
      xdest_wdata_out <= '0;
    end
    else
    begin
      br_valid_out <= br_valid_in;
      br_target_out <= br_valid_in ? br_target : br_target_out;
      br_in_flash_out <= br_valid_in ? (br_target <= CMSD_FLASH_LAST) : br_in_flash_out;
      opcode_nop_out <= is_nop;
      flash_wr_out <= xmove_wr_in && to_flash && flash_ok;
      xram_wr_out <= xmove_wr_in && !to_flash;
      flash_range_err_out <= xmove_wr_in && to_flash && !flash_ok;
      xdest_addr_out <= xmove_wr_in ? xmove_addr_in : xdest_addr_out;
      xdest_wdata_out <= xmove_wr_in ? xmove_wdata_in : xdest_wdata_out;
    end
  end

endmodule : cmsd_decoder

`default_nettype wire

// File: hw/cmsd_pkg.sv
package cmsd_pkg;

  // Request kinds offered by the execution unit; the kind alone decides bit versus byte handling.
  typedef enum logic [3:0] {
    CMSD_REQ_BANK_REG,
    CMSD_REQ_INDIRECT,
    CMSD_REQ_DIRECT,
    CMSD_REQ_BIT,
    CMSD_REQ_PUSH,
    CMSD_REQ_POP,
    CMSD_REQ_CALL,
    CMSD_REQ_RET,
    CMSD_REQ_SP_INC,
    CMSD_REQ_SP_DEC
  } cmsd_req_e;

  // Branch target kinds: relative, absolute within a page, and long.
  typedef enum logic [1:0] {
    CMSD_BR_REL,
    CMSD_BR_ABS,
    CMSD_BR_LONG
  } cmsd_br_e;

  // Data space layout.
  localparam logic [7:0] CMSD_SP_SFR_ADDR = 8'h81;
  localparam logic [7:0] CMSD_SP_RESET = 8'h07;
  localparam logic [7:0] CMSD_BIT_RAM_BASE = 8'h20;
  localparam int CMSD_UPPER_SEL_BIT = 7;
  localparam int CMSD_RAM_BYTES = 256;
  localparam int CMSD_DATA_BITS = 8;

  // Program status word bank select and program store control write enable positions.
  localparam int CMSD_PSW_BANK_LOW_BIT = 3;
  localparam int CMSD_PSW_BANK_HIGH_BIT = 4;
  localparam int CMSD_PROGRAM_STORE_CONTROL_WE_BIT = 0;

  // Program memory layout.
  localparam logic [15:0] CMSD_FLASH_LAST = 16'h207F;
  localparam logic [15:0] CMSD_FACTORY_FIRST = 16'h1E00;
  localparam logic [15:0] CMSD_FACTORY_LAST = 16'h1FFF;
  localparam int CMSD_ABS_BITS = 11;

  // Opcodes that behave as the no_operation instruction.
  localparam logic [7:0] CMSD_OP_NOP = 8'h00;
  localparam logic [7:0] CMSD_OP_ALT_NOP = 8'hA5;

  // Stack record depth in bits.
  localparam int CMSD_REC_BITS = 32;

endpackage : cmsd_pkg

// File: hw/cmsd_ram.sv
`timescale 1ns/1ps
`default_nettype none

module cmsd_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  input wire logic core_clk_in,                     // System clock.
  input wire logic sys_rst_in,                      // Synchronous reset, clears the read register only.
  input wire logic [$clog2(DEPTH)-1:0] addr_in,     // Byte address.
  input wire logic wr_in,                           // Write strobe.
  input wire logic [WIDTH-1:0] wdata_in,            // Write data.
  output logic [WIDTH-1:0] rdata_out                // Registered read data, one cycle after the address.
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // The array holds no reset so it maps onto plain RAM cells.
  always_ff @(posedge core_clk_in)
  begin
    if (wr_in)
    begin
      mem_q[addr_in] <= wdata_in;
    end
  end

  // Read data always comes from a register; a write cycle returns the old contents.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= '0;
    end
    else
    begin
      rdata_out <= mem_q[addr_in];
    end
  end

endmodule : cmsd_ram

`default_nettype wire

// File: sim/cmsd_props.sv
`timescale 1ns/1ps
`default_nettype none
module cmsd_props
  import cmsd_pkg::*;
(
  input wire logic core_clk_in, // Clock.
  input wire logic sys_rst_in, // Reset.
  input wire logic req_valid_in, // Offer.
  input wire logic req_ready_out, // Ready.
  input wire cmsd_req_e req_kind_in, // Kind.
  input wire logic [7:0] req_field_in, // Field.
  input wire logic done_out, // Done.
  input wire logic [7:0] stack_pointer_out, // Pointer.
  input wire logic sfr_rd_out, // Read.
  input wire logic sfr_wr_out, // Write.
  input wire logic [7:0] sfr_addr_out, // Address.
  input wire logic br_valid_in, // Branch.
  input wire cmsd_br_e br_kind_in, // Kind.
  input wire logic [15:0] br_next_pc_in, // Next.
  input wire logic [15:0] br_field_in, // Field.
  input wire logic [15:0] br_target_out, // Target.
  input wire logic [7:0] opcode_in, // Opcode.
  input wire logic opcode_nop_out, // Idle op.
  input wire logic [7:0] program_store_control_in, // Control.
  input wire logic xmove_wr_in, // Move.
  input wire logic [15:0] xmove_addr_in, // Address.
  input wire logic flash_wr_out, // Flash.
  input wire logic xram_wr_out // Data.
);
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire go = req_valid_in && req_ready_out;
  // Request kinds that have several steps.
  sequence push_go;
    go && req_kind_in == CMSD_REQ_PUSH;
  endsequence
  sequence sfr_go;
    go && req_kind_in == CMSD_REQ_DIRECT && req_field_in[7] && req_field_in != 8'h81;
  endsequence
  chk_sp_reset_value: assert property ($fell(sys_rst_in) |-> stack_pointer_out == 8'h07)
    else $error("stack pointer not 07 after reset");
  chk_push_sp_step: assert property (push_go |=> ##1 done_out && stack_pointer_out == $past(stack_pointer_out, 2) + 8'h01)
    else $error("push did not advance the pointer by one");
  chk_direct_to_sfr: assert property (sfr_go |=> (sfr_rd_out || sfr_wr_out) && sfr_addr_out == $past(req_field_in))
    else $error("direct upper access missed the register space");
  chk_branch_rel: assert property (br_valid_in && br_kind_in == CMSD_BR_REL |=>
    br_target_out == $past(br_next_pc_in) + {{8{$past(br_field_in[7])}}, $past(br_field_in[7:0])})
    else $error("relative target wrong");
  chk_branch_abs: assert property (br_valid_in && br_kind_in == CMSD_BR_ABS |=>
    br_target_out == {$past(br_next_pc_in[15:11]), $past(br_field_in[10:0])})
    else $error("absolute target left its page");
  chk_branch_long: assert property (br_valid_in && br_kind_in == CMSD_BR_LONG |=> br_target_out == $past(br_field_in))
    else $error("long target wrong");
  chk_alt_nop: assert property (opcode_in == 8'hA5 |=> opcode_nop_out)
    else $error("opcode A5 not idle");
  chk_flash_redirect: assert property (xmove_wr_in && program_store_control_in[0] && xmove_addr_in <= 16'h207F |=>
    flash_wr_out && !xram_wr_out)
    else $error("enabled write not sent to flash");
endmodule : cmsd_props
bind cmsd_decoder cmsd_props chk_u (.core_clk_in, .sys_rst_in, .req_valid_in, .req_ready_out, .req_kind_in,
  .req_field_in, .done_out, .stack_pointer_out, .sfr_rd_out, .sfr_wr_out, .sfr_addr_out, .br_valid_in, .br_kind_in,
  .br_next_pc_in, .br_field_in, .br_target_out, .opcode_in, .opcode_nop_out, .program_store_control_in,
  .xmove_wr_in, .xmove_addr_in, .flash_wr_out, .xram_wr_out);
`default_nettype wire

// File: sim/cmsd_sfr_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmsd_sfr_model (
  input wire logic clk_in, // Clock.
  input wire logic rd_in, // Read strobe.
  input wire logic wr_in, // Write strobe.
  input wire logic [7:0] addr_in, // Address.
  input wire logic [7:0] wdata_in, // Write data.
  output logic [7:0] rdata_out // Read data.
);
  logic [7:0] regs_q [0:255];
  // Separate register space; idle cycles flip the data so a stale byte never passes.
  always_ff @(posedge clk_in)
  begin
    if (wr_in)
      regs_q[addr_in] <= wdata_in;
    rdata_out <= rd_in ? regs_q[addr_in] : ~rdata_out;
  end
endmodule : cmsd_sfr_model
`default_nettype wire

// File: sim/cmsd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module cmsd_decoder_test;
  import cmsd_pkg::*;
  localparam int RB = 4;
  logic core_clk_in = 0, sys_rst_in = 1, req_valid_in = 0, req_write_in = 0, req_bit_in = 0, br_valid_in = 0;
  logic xmove_wr_in = 0, req_ready_out, done_out, sfr_rd_out, sfr_wr_out, stack_overflow_out, stack_underflow_out;
  logic br_valid_out, br_in_flash_out, opcode_nop_out, flash_wr_out, xram_wr_out, flash_range_err_out;
  cmsd_req_e req_kind_in = CMSD_REQ_DIRECT;
  cmsd_br_e br_kind_in = CMSD_BR_REL;
  logic [7:0] req_field_in = '0, program_status_word_in = '0, opcode_in = '0, program_store_control_in = '0;
  logic [7:0] xmove_wdata_in = '0, sfr_rdata_in, stack_pointer_out, sfr_addr_out, sfr_wdata_out, xdest_wdata_out;
  logic [15:0] req_wdata_in = '0, br_next_pc_in = '0, br_field_in = '0, xmove_addr_in = '0, rdata_out;
  logic [15:0] br_target_out, xdest_addr_out, got;
  logic [$clog2(RB+1)-1:0] stack_depth_out;
  logic [RB-1:0] stack_record_out;
  logic ov_seen = 0, un_seen = 0;
  int errors = 0, n_checks = 0, cyc = 0;
  cmsd_decoder #(.REC_BITS(RB)) dut_u (.core_clk_in, .sys_rst_in, .req_valid_in, .req_ready_out, .req_kind_in,
    .req_write_in, .req_field_in, .req_wdata_in, .req_bit_in, .done_out, .rdata_out, .program_status_word_in,
    .stack_pointer_out, .sfr_rd_out, .sfr_wr_out, .sfr_addr_out, .sfr_wdata_out, .sfr_rdata_in, .stack_overflow_out,
    .stack_underflow_out, .stack_depth_out, .stack_record_out, .br_valid_in, .br_kind_in, .br_next_pc_in,
    .br_field_in, .br_valid_out, .br_target_out, .br_in_flash_out, .opcode_in, .opcode_nop_out,
    .program_store_control_in, .xmove_wr_in, .xmove_addr_in, .xmove_wdata_in, .flash_wr_out, .xram_wr_out,
    .flash_range_err_out, .xdest_addr_out, .xdest_wdata_out);
  cmsd_sfr_model sfr_u (.clk_in(core_clk_in), .rd_in(sfr_rd_out), .wr_in(sfr_wr_out), .addr_in(sfr_addr_out),
    .wdata_in(sfr_wdata_out), .rdata_out(sfr_rdata_in));
  always #20 core_clk_in = ~core_clk_in;
  // Debug pulses last one cycle, so keep sticky copies; the cycle cap stops a hang.
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (stack_overflow_out === 1'b1) ov_seen = 1'b1;
    if (stack_underflow_out === 1'b1) un_seen = 1'b1;
    if (cyc == 3000) begin errors++; give_verdict(); end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held from a falling edge until a rising edge finds ready high, then wait for done.
  task automatic rq(input cmsd_req_e k, input logic w, input logic [7:0] f, input logic [15:0] d);
    int n = 0;
    @(negedge core_clk_in);
    req_kind_in = k;
    {req_write_in, req_field_in, req_wdata_in, req_bit_in, req_valid_in} = {w, f, d, d[0], 1'b1};
    while (req_ready_out !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 20) begin @(negedge core_clk_in); n++; end
    if (n == 20) begin errors++; give_verdict(); end
    got = rdata_out;
  endtask : rq
  task automatic rd(input cmsd_req_e k, input logic [7:0] f, input logic [15:0] e);
    rq(k, 1'b0, f, 16'h0000);
    chk("rdata", got & ((k == CMSD_REQ_RET) ? 16'hFFFF : (k == CMSD_REQ_BIT) ? 16'h0001 : 16'h00FF), e);
  endtask : rd
  task automatic br(input cmsd_br_e k, input logic [15:0] pc, input logic [15:0] f, input logic [15:0] e);
    @(negedge core_clk_in);
    br_kind_in = k;
    {br_next_pc_in, br_field_in, br_valid_in} = {pc, f, 1'b1};
    @(negedge core_clk_in);
    br_valid_in = 1'b0;
    chk("target", br_target_out, e);
    chk("br_out", {14'h0000, br_valid_out, br_in_flash_out}, {14'h0000, 1'b1, e <= 16'h207F});
  endtask : br
  task automatic xm(input logic [7:0] c, input logic [15:0] a, input logic [2:0] e);
    @(negedge core_clk_in);
    {program_store_control_in, xmove_addr_in, xmove_wdata_in, xmove_wr_in} = {c, a, 8'h5C, 1'b1};
    @(negedge core_clk_in);
    xmove_wr_in = 1'b0;
    chk("xmove", {5'h00, xdest_wdata_out, flash_wr_out, xram_wr_out, flash_range_err_out}, {5'h00, 8'h5C, e});
    chk("xdest", xdest_addr_out, a);
  endtask : xm
  // Main sequence; SFR addresses used are occupied ones.
  initial
  begin
    repeat (5) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    rd(CMSD_REQ_DIRECT, 8'h81, 16'h0007);
    for (int b = 0; b < 4; b++)
    begin
      program_status_word_in = 8'(b << 3);
      rq(CMSD_REQ_BANK_REG, 1'b1, 8'(b + 3), 16'(8'h30 + b));
      rd(CMSD_REQ_DIRECT, 8'(b * 9 + 3), 16'(8'h30 + b));
    end
    program_status_word_in = 8'h00;
    rq(CMSD_REQ_BANK_REG, 1'b1, 8'h01, 16'h00C5);
    rq(CMSD_REQ_INDIRECT, 1'b1, 8'h01, 16'h005A);
    rq(CMSD_REQ_DIRECT, 1'b1, 8'hC5, 16'h00A3);
    rd(CMSD_REQ_INDIRECT, 8'h01, 16'h005A);
    rd(CMSD_REQ_DIRECT, 8'hC5, 16'h00A3);
    rq(CMSD_REQ_DIRECT, 1'b1, 8'h22, 16'h0000);
    rq(CMSD_REQ_BIT, 1'b1, 8'h13, 16'h0001);
    rd(CMSD_REQ_DIRECT, 8'h22, 16'h0008);
    rd(CMSD_REQ_BIT, 8'h13, 16'h0001);
    rq(CMSD_REQ_DIRECT, 1'b1, 8'h90, 16'h0000);
    rq(CMSD_REQ_BIT, 1'b1, 8'h93, 16'h0001);
    rd(CMSD_REQ_DIRECT, 8'h90, 16'h0008);
    rq(CMSD_REQ_PUSH, 1'b0, 8'h00, 16'h00AB);
    rd(CMSD_REQ_DIRECT, 8'h08, 16'h00AB);
    rq(CMSD_REQ_CALL, 1'b0, 8'h00, 16'h1234);
    chk("sp", {4'h0, stack_record_out, stack_pointer_out}, 16'h030A);
    rd(CMSD_REQ_RET, 8'h00, 16'h1234);
    rd(CMSD_REQ_POP, 8'h00, 16'h00AB);
    repeat (5) rq(CMSD_REQ_SP_INC, 1'b0, 8'h00, 16'h0000);
    chk("overflow", {15'h0000, ov_seen}, 16'h0001);
    chk("depth", 16'(stack_depth_out), 16'h0004);
    rd(CMSD_REQ_SP_DEC, 8'h00, 16'h000B);
    repeat (4) rq(CMSD_REQ_SP_DEC, 1'b0, 8'h00, 16'h0000);
    chk("underflow", {15'h0000, un_seen}, 16'h0001);
    rq(CMSD_REQ_DIRECT, 1'b1, 8'h81, 16'h00FF);
    rq(CMSD_REQ_PUSH, 1'b0, 8'h00, 16'h0077);
    rd(CMSD_REQ_DIRECT, 8'h00, 16'h0077);
    br(CMSD_BR_REL, 16'h0102, 16'h00FE, 16'h0100);
    br(CMSD_BR_ABS, 16'h0FFE, 16'h0123, 16'h0923);
    br(CMSD_BR_LONG, 16'h0100, 16'h207F, 16'h207F);
    br(CMSD_BR_LONG, 16'h0100, 16'h2080, 16'h2080);
    xm(8'h01, 16'h1000, 3'b100);
    xm(8'h00, 16'h1000, 3'b010);
    xm(8'h01, 16'h2080, 3'b001);
    foreach (opcode_in[i])
    begin
      @(negedge core_clk_in);
      opcode_in = (i == 0) ? 8'hA5 : (i == 1) ? 8'h00 : 8'(8'hA4 + i);
      @(negedge core_clk_in);
      chk("nop", {15'h0000, opcode_nop_out}, {15'h0000, i < 2});
    end
    sys_rst_in = 1'b1;
    @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    rd(CMSD_REQ_DIRECT, 8'h81, 16'h0007);
    give_verdict();
  end
endmodule : cmsd_decoder_test
`default_nettype wire
